// ==== logic/ppd_port.sv ====
// Pin driver for up to eight legacy 17-line parallel ports.
// Assumes pin inputs synchronous to core_clk; host pulses read/write.
module ppd_port
  import ppd_pkg::*;
(
  // Clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  rst,
  // Configuration
  input  wire logic                                  cfg_valid,
  input  wire logic [ppd_pkg::PPD_IDX_W-1:0]         cfg_port,
  input  wire logic                                  cfg_addr_given,
  input  wire logic [ppd_pkg::PPD_ADDR_W-1:0]        cfg_addr,
  input  wire logic                                  cfg_dir_given,
  input  wire logic [1:0]                            cfg_dir,
  output logic                                       cfg_error,
  output logic [ppd_pkg::PPD_PORTS-1:0]              port_present,
  output logic [ppd_pkg::PPD_PORTS*16-1:0]           port_base,
  output logic [ppd_pkg::PPD_PORTS*2-1:0]            port_dir,
  // Settings per port
  input  wire logic [ppd_pkg::PPD_PORTS*8-1:0]       data_invert,
  input  wire logic [ppd_pkg::PPD_PORTS*4-1:0]       ctrl_invert,
  input  wire logic [ppd_pkg::PPD_PORTS*8-1:0]       data_ret_en,
  input  wire logic [ppd_pkg::PPD_PORTS*32-1:0]      ret_time_ns,
  // Operations: per port and all-ports
  input  wire logic [ppd_pkg::PPD_PORTS-1:0]         read_req,
  input  wire logic                                  read_all,
  input  wire logic [ppd_pkg::PPD_PORTS-1:0]         write_req,
  input  wire logic                                  write_all,
  input  wire logic [ppd_pkg::PPD_PORTS-1:0]         ret_req,
  output logic [ppd_pkg::PPD_PORTS-1:0]              ret_busy,
  // Requested output values
  input  wire logic [ppd_pkg::PPD_PORTS*8-1:0]       data_out_req,
  input  wire logic [ppd_pkg::PPD_PORTS*4-1:0]       ctrl_out_req,
  // Sampled inputs, true and inverted
  output logic [ppd_pkg::PPD_PORTS*8-1:0]            data_in,
  output logic [ppd_pkg::PPD_PORTS*8-1:0]            data_in_n,
  output logic [ppd_pkg::PPD_PORTS*4-1:0]            ctrl_in,
  output logic [ppd_pkg::PPD_PORTS*4-1:0]            ctrl_in_n,
  output logic [ppd_pkg::PPD_PORTS*5-1:0]            stat_in,
  output logic [ppd_pkg::PPD_PORTS*5-1:0]            stat_in_n,
  // Physical lines
  input  wire logic [ppd_pkg::PPD_PORTS*8-1:0]       data_pin_i,
  output logic [ppd_pkg::PPD_PORTS*8-1:0]            data_pin_o,
  output logic [ppd_pkg::PPD_PORTS*8-1:0]            data_pin_oe,
  input  wire logic [ppd_pkg::PPD_PORTS*4-1:0]       ctrl_pin_i,
  output logic [ppd_pkg::PPD_PORTS*4-1:0]            ctrl_pin_o,
  output logic [ppd_pkg::PPD_PORTS*4-1:0]            ctrl_pin_oe,
  input  wire logic [ppd_pkg::PPD_PORTS*5-1:0]       stat_pin_i
);

  logic [PPD_DATA_W-1:0] data_lvl   [PPD_PORTS];
  logic [PPD_CTRL_W-1:0] ctrl_lvl   [PPD_PORTS];
  logic [PPD_NS_W-1:0]   ret_cnt    [PPD_PORTS];
  logic [PPD_NS_W-1:0]   next_cnt   [PPD_PORTS];
  ppd_ret_e              ret_st     [PPD_PORTS];
  logic [PPD_PORTS-1:0]  do_rd;
  logic [PPD_PORTS-1:0]  do_wr;
  logic [PPD_PORTS-1:0]  ret_done;

  // All-port strobes fan out to each present port
  assign do_rd = (read_req | {PPD_PORTS{read_all}}) & port_present;
  assign do_wr = (write_req | {PPD_PORTS{write_all}}) & port_present;

  // Configuration: a port is set up once; later attempts flag an error
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port_present <= '0;
      port_base    <= '0;
      port_dir     <= '0;
      cfg_error    <= 1'b0;
    end else if (cfg_valid) begin
      if (!cfg_addr_given || port_present[cfg_port]) begin
        cfg_error <= 1'b1;
      end else begin
        cfg_error <= 1'b0;
        port_present[cfg_port] <= 1'b1;
        port_base[cfg_port*16 +: 16] <= cfg_addr;
        port_dir[cfg_port*2 +: 2] <= (cfg_dir_given && cfg_dir != 2'h3)
                                     ? cfg_dir : PPD_DIR_DEFAULT;
      end
    end
  end

  // Output latches, input samples and return timers per port
  for (genvar p = 0; p < PPD_PORTS; p++) begin : g_port
    logic [1:0] dir;
    logic       is_out;
    logic       is_in;
    logic       is_oc;
    assign dir    = port_dir[p*2 +: 2];
    assign is_out = port_present[p] && dir == PPD_DIR_OUT;
    assign is_in  = port_present[p] && dir == PPD_DIR_IN;
    assign is_oc  = port_present[p] && dir == PPD_DIR_OC;
    assign ret_done[p] = ret_st[p] == PPD_WAIT && ret_cnt[p] <= 1;

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        data_lvl[p] <= PPD_DATA_RST;
        ctrl_lvl[p] <= PPD_CTRL_RST;
      end else if (do_wr[p]) begin
        data_lvl[p] <= data_out_req[p*8 +: 8] ^ data_invert[p*8 +: 8];
        ctrl_lvl[p] <= ctrl_out_req[p*4 +: 4] ^ ctrl_invert[p*4 +: 4];
      end else if (ret_done[p]) begin
        data_lvl[p] <= (data_lvl[p] & ~data_ret_en[p*8 +: 8])
                     | (data_invert[p*8 +: 8] & data_ret_en[p*8 +: 8]);
      end
    end

    // Return timer: loaded on write, return acts once it has run out
    always_comb begin
      next_cnt[p] = ppd_ns_to_cyc(ret_time_ns[p*32 +: 32]);
    end

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        ret_st[p]  <= PPD_IDLE;
        ret_cnt[p] <= '0;
      end else if (do_wr[p]) begin
        ret_cnt[p] <= next_cnt[p];
        ret_st[p]  <= PPD_IDLE;
      end else begin
        if (ret_cnt[p] != '0)
          ret_cnt[p] <= ret_cnt[p] - 1'b1;
        case (ret_st[p])
          PPD_IDLE: begin
            if (ret_req[p] && port_present[p])
              ret_st[p] <= PPD_WAIT;
          end
          PPD_WAIT: begin
            if (ret_done[p])
              ret_st[p] <= PPD_IDLE;
          end
          default: ret_st[p] <= PPD_IDLE;
        endcase
      end
    end
    assign ret_busy[p] = ret_st[p] == PPD_WAIT;

    // Input sampling on read
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        data_in[p*8 +: 8]   <= '0;
        data_in_n[p*8 +: 8] <= '0;
        ctrl_in[p*4 +: 4]   <= '0;
        ctrl_in_n[p*4 +: 4] <= '0;
        stat_in[p*5 +: 5]   <= '0;
        stat_in_n[p*5 +: 5] <= '0;
      end else if (do_rd[p]) begin
        stat_in[p*5 +: 5]   <= stat_pin_i[p*5 +: 5];
        stat_in_n[p*5 +: 5] <= ~stat_pin_i[p*5 +: 5];
        if (is_in) begin
          data_in[p*8 +: 8]   <= data_pin_i[p*8 +: 8];
          data_in_n[p*8 +: 8] <= ~data_pin_i[p*8 +: 8];
        end
        if (is_oc) begin
          ctrl_in[p*4 +: 4]   <= ctrl_pin_i[p*4 +: 4];
          ctrl_in_n[p*4 +: 4] <= ~ctrl_pin_i[p*4 +: 4];
        end
      end
    end

    // Pin drive; open collector only pulls the control lines low so the far end can too
    assign data_pin_o[p*8 +: 8]  = data_lvl[p];
    assign data_pin_oe[p*8 +: 8] = {PPD_DATA_W{is_out || is_oc}};
    assign ctrl_pin_o[p*4 +: 4]  = ctrl_lvl[p];
    assign ctrl_pin_oe[p*4 +: 4] = is_oc ? ~ctrl_lvl[p]
                                 : {PPD_CTRL_W{port_present[p]}};

    property p_write_drives;
      @(posedge core_clk) disable iff (rst)
      do_wr[p] |=> data_lvl[p] ==
        $past(data_out_req[p*8 +: 8] ^ data_invert[p*8 +: 8]);
    endproperty
    a_write_drives: assert property (p_write_drives)
      else $error("data level not taken from write");

    property p_read_inverse;
      @(posedge core_clk) disable iff (rst)
      do_rd[p] |=> stat_in[p*5 +: 5] == ~stat_in_n[p*5 +: 5]
        && stat_in[p*5 +: 5] == $past(stat_pin_i[p*5 +: 5]);
    endproperty
    a_read_inverse: assert property (p_read_inverse)
      else $error("status sample or inverse wrong");

    property p_data_oe;
      @(posedge core_clk) disable iff (rst)
      is_in |-> data_pin_oe[p*8 +: 8] == '0;
    endproperty
    a_data_oe: assert property (p_data_oe)
      else $error("data driven in input mode");

    property p_ctrl_out;
      @(posedge core_clk) disable iff (rst)
      (is_out || is_in) |-> ctrl_pin_oe[p*4 +: 4] == 4'hF;
    endproperty
    a_ctrl_out: assert property (p_ctrl_out)
      else $error("control not driven");

    property p_dir_fixed;
      @(posedge core_clk) disable iff (rst)
      port_present[p] |=> port_present[p] && $stable(port_dir[p*2 +: 2]);
    endproperty
    a_dir_fixed: assert property (p_dir_fixed)
      else $error("direction changed after configuration");

    property p_no_early_return;
      @(posedge core_clk) disable iff (rst)
      (ret_busy[p] && !do_wr[p] && ret_cnt[p] > 1) |=>
        data_lvl[p] == $past(data_lvl[p]);
    endproperty
    a_no_early_return: assert property (p_no_early_return)
      else $error("return acted before delay");

    property p_return_level;
      @(posedge core_clk) disable iff (rst)
      (ret_done[p] && !do_wr[p]) |=>
        ((data_lvl[p] ^ data_invert[p*8 +: 8]) & data_ret_en[p*8 +: 8])
          == '0;
    endproperty
    a_return_level: assert property (p_return_level)
      else $error("returned output not at polarity level");

    property p_load_count;
      @(posedge core_clk) disable iff (rst)
      do_wr[p] |=> ret_cnt[p] == $past(next_cnt[p]) && next_cnt[p] != 0;
    endproperty
    a_load_count: assert property (p_load_count)
      else $error("return count not loaded at write");
  end

  property p_no_addr;
    @(posedge core_clk) disable iff (rst)
    (cfg_valid && !cfg_addr_given) |=> cfg_error
      && port_present == $past(port_present);
  endproperty
  a_no_addr: assert property (p_no_addr)
    else $error("config without address accepted");

endmodule // ppd_port

// ==== shared/ppd_pkg.sv ====
// Constants for the parallel port pin driver.
// Assumes a single 40 MHz core clock.
package ppd_pkg;
  localparam int          PPD_PORTS      = 8;
  localparam int          PPD_DATA_W     = 8;
  localparam int          PPD_CTRL_W     = 4;
  localparam int          PPD_STAT_W     = 5;
  localparam int          PPD_IDX_W      = 3;
  localparam int          PPD_ADDR_W     = 16;
  localparam int          PPD_NS_W       = 32;
  localparam int          PPD_CLK_PERIOD_NS = 25;
  localparam logic [1:0]  PPD_DIR_OUT    = 2'h0;
  localparam logic [1:0]  PPD_DIR_IN     = 2'h1;
  localparam logic [1:0]  PPD_DIR_OC     = 2'h2;
  localparam logic [1:0]  PPD_DIR_DEFAULT = PPD_DIR_OUT;
  localparam logic [7:0]  PPD_DATA_RST   = 8'h00;
  localparam logic [3:0]  PPD_CTRL_RST   = 4'h0;

  typedef enum logic [1:0] {
    PPD_IDLE = 2'b01,
    PPD_WAIT = 2'b10
  } ppd_ret_e;

  // Nanoseconds to clock cycles, rounded up, at least one
  function automatic logic [PPD_NS_W-1:0] ppd_ns_to_cyc(
    input logic [PPD_NS_W-1:0] ns);
    logic [PPD_NS_W:0] c;
    c = ({1'b0, ns} + (PPD_NS_W+1)'(PPD_CLK_PERIOD_NS - 1))
        / (PPD_NS_W+1)'(PPD_CLK_PERIOD_NS);
    if (c == '0)
      c = (PPD_NS_W+1)'(1);
    return c[PPD_NS_W-1:0];
  endfunction
endpackage

// ==== test/ppd_partner.sv ====
// Equipment wired to the connector lines of all eight ports.
// Assumes the bench supplies the levels the equipment drives.
module ppd_partner (
  // Lines from the pin driver
  input  wire logic [63:0] data_pin_o,
  input  wire logic [63:0] data_pin_oe,
  input  wire logic [31:0] ctrl_pin_o,
  input  wire logic [31:0] ctrl_pin_oe,
  // Levels the equipment drives
  input  wire logic [63:0] ext_data,
  input  wire logic [31:0] ext_ctrl,
  input  wire logic [39:0] ext_stat,
  // Resolved line levels
  output logic      [63:0] data_pin_i,
  output logic      [31:0] ctrl_pin_i,
  output logic      [39:0] stat_pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released lines follow the equipment, never the last driven value
  assign data_pin_i = (data_pin_oe & data_pin_o) | (~data_pin_oe & ext_data);
  assign ctrl_pin_i = (ctrl_pin_oe & ctrl_pin_o) | (~ctrl_pin_oe & ext_ctrl);
  assign stat_pin_i = ext_stat;
endmodule // ppd_partner

// ==== test/tb_parallel_port_pin_driver.sv ====
// Self-checking bench for the parallel port pin driver.
// Assumes the partner model on the pins and a 40 MHz clock.
module tb_parallel_port_pin_driver;
  timeunit 1ns;
  timeprecision 1ps;
  import ppd_pkg::*;
  typedef struct {int due; int id; int p; logic [15:0] v;} ppd_note_s;
  logic core_clk, rst, cfg_valid, cfg_addr_given, cfg_dir_given, cfg_error;
  logic read_all, write_all;
  logic [2:0] cfg_port;
  logic [15:0] cfg_addr, s;
  logic [1:0] cfg_dir;
  logic [7:0] port_present, read_req, write_req, ret_req, ret_busy, w;
  logic [127:0] port_base;
  logic [15:0] port_dir;
  logic [63:0] data_invert, data_ret_en, data_out_req, data_in, data_in_n;
  logic [63:0] data_pin_i, data_pin_o, data_pin_oe, ext_data;
  logic [255:0] ret_time_ns;
  logic [31:0] ctrl_invert, ctrl_out_req, ctrl_in, ctrl_in_n, ext_ctrl;
  logic [31:0] ctrl_pin_i, ctrl_pin_o, ctrl_pin_oe;
  logic [39:0] stat_in, stat_in_n, stat_pin_i, ext_stat;
  logic [3:0] cw;
  int seed = 11, cyc = 0, bad_count = 0, checks = 0, p, k, m;
  int tt [5] = '{0, 1, 50, 51, 250};
  ppd_note_s q [$];
  ppd_note_s n;
  string nm [15] = '{"cfg_error", "port_dir", "port_base", "data_pin_o",
    "data_pin_oe", "ctrl_pin_o", "ctrl_pin_oe", "data_in", "data_in_n",
    "ctrl_in", "stat_in", "stat_in_n", "ret_busy", "port_present",
    "ctrl_in_n"};

  ppd_port ppd_port_i (.core_clk, .rst, .cfg_valid, .cfg_port,
    .cfg_addr_given, .cfg_addr, .cfg_dir_given, .cfg_dir, .cfg_error,
    .port_present, .port_base, .port_dir, .data_invert, .ctrl_invert,
    .data_ret_en, .ret_time_ns, .read_req, .read_all, .write_req,
    .write_all, .ret_req, .ret_busy, .data_out_req, .ctrl_out_req,
    .data_in, .data_in_n, .ctrl_in, .ctrl_in_n, .stat_in, .stat_in_n,
    .data_pin_i, .data_pin_o, .data_pin_oe, .ctrl_pin_i, .ctrl_pin_o,
    .ctrl_pin_oe, .stat_pin_i);
  ppd_partner ppd_partner_i (.data_pin_o, .data_pin_oe, .ctrl_pin_o,
    .ctrl_pin_oe, .ext_data, .ext_ctrl, .ext_stat, .data_pin_i,
    .ctrl_pin_i, .stat_pin_i);

  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input int id, input logic [15:0] sn, e);
    checks++;
    if (sn !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm[id], e, sn);
    end
  endtask

  // Note an expected value, due d clock edges after this falling edge
  task automatic ex(input int id, pi, d, input logic [15:0] v);
    q.push_back(ppd_note_s'{cyc + d, id, pi, v});
  endtask

  task automatic go(input logic cv, input logic [7:0] rd, input logic ra,
                    input logic [7:0] wr, input logic wa,
                    input logic [7:0] rr);
    @(negedge core_clk);
    cfg_valid = cv;
    read_req = rd;
    read_all = ra;
    write_req = wr;
    write_all = wa;
    ret_req = rr;
  endtask

  // Outputs settle after the rising edge; compare each due note
  always @(negedge core_clk) begin
    #2;
    while (q.size() > 0 && q[0].due <= cyc) begin
      n = q.pop_front();
      case (n.id)
        0: s = 16'(cfg_error);
        1: s = 16'(port_dir[n.p*2 +: 2]);
        2: s = port_base[n.p*16 +: 16];
        3: s = 16'(data_pin_o[n.p*8 +: 8]);
        4: s = 16'(data_pin_oe[n.p*8 +: 8]);
        5: s = 16'(ctrl_pin_o[n.p*4 +: 4]);
        6: s = 16'(ctrl_pin_oe[n.p*4 +: 4]);
        7: s = 16'(data_in[n.p*8 +: 8]);
        8: s = 16'(data_in_n[n.p*8 +: 8]);
        9: s = 16'(ctrl_in[n.p*4 +: 4]);
        10: s = 16'(stat_in[n.p*5 +: 5]);
        11: s = 16'(stat_in_n[n.p*5 +: 5]);
        12: s = 16'(ret_busy[n.p]);
        14: s = 16'(ctrl_in_n[n.p*4 +: 4]);
        default: s = 16'(port_present[n.p]);
      endcase
      check(n.id, s, n.v);
    end
  end

  initial begin
    #500000;
    bad_count++;
    end_of_test();
  end

  initial begin
    {rst, cfg_valid, cfg_port, cfg_addr_given, cfg_addr} = '0;
    {cfg_dir_given, cfg_dir, data_invert, ctrl_invert, data_ret_en} = '0;
    {ret_time_ns, read_req, read_all, write_req, write_all, ret_req} = '0;
    {data_out_req, ctrl_out_req, ext_data, ext_ctrl, ext_stat} = '0;
    rst = 1;
    repeat (2) @(negedge core_clk);
    rst = 0;
    for (int i = 0; i < 4; i++) begin
      p = (i == 3) ? 7 : i;
      cfg_port = 3'(p);
      cfg_addr = 16'($random(seed));
      cfg_addr_given = 1;
      cfg_dir_given = (i != 0);
      cfg_dir = 2'(i);
      go(1, 0, 0, 0, 0, 0);
      ex(0, p, 1, 0);
      ex(13, p, 1, 1);
      ex(1, p, 1, (i == 1 || i == 2) ? 2'(i) : PPD_DIR_DEFAULT);
      ex(2, p, 1, cfg_addr);
      // Strobe drops before the next fields change
      go(0, 0, 0, 0, 0, 0);
    end
    cfg_port = 3'h3;
    cfg_addr_given = 0;
    go(1, 0, 0, 0, 0, 0);
    ex(0, 3, 1, 1);
    ex(13, 3, 1, 0);
    go(0, 0, 0, 0, 0, 0);
    cfg_port = 3'h0;
    cfg_addr_given = 1;
    cfg_dir = PPD_DIR_IN;
    go(1, 0, 0, 0, 0, 0);
    ex(0, 0, 1, 1);
    ex(1, 0, 1, PPD_DIR_OUT);
    go(0, 0, 0, 0, 0, 0);
    for (int r = 0; r < 4; r++) begin
      data_out_req = {$random(seed), $random(seed)};
      ctrl_out_req = $random(seed);
      data_invert = {$random(seed), $random(seed)};
      ctrl_invert = $random(seed);
      go(0, 0, 0, 0, 1, 0);
      for (p = 0; p < 8; p += 2) begin
        w = data_out_req[p*8 +: 8] ^ data_invert[p*8 +: 8];
        cw = ctrl_out_req[p*4 +: 4] ^ ctrl_invert[p*4 +: 4];
        ex(3, p, 1, (p < 4) ? w : 8'h00);
        ex(5, p, 1, (p < 4) ? cw : 4'h0);
        if (p < 4) ex(6, p, 1, (p == 2) ? 4'(~cw) : 4'hF);
      end
      ex(4, 0, 1, 16'h00FF);
      ex(4, 1, 1, 16'h0000);
      ex(6, 1, 1, 16'h000F);
      ext_data = {$random(seed), $random(seed)};
      ext_ctrl = $random(seed);
      ext_stat = 40'({$random(seed), $random(seed)});
      go(0, (r % 2 == 1) ? 8'h07 : 8'h00, r % 2 == 0, 0, 0, 0);
      ex(7, 1, 1, ext_data[15:8]);
      ex(8, 1, 1, 8'(~ext_data[15:8]));
      ex(7, 0, 1, 0);
      // Open-collector port 2 reads back its own low pulls
      cw = ctrl_out_req[11:8] ^ ctrl_invert[11:8];
      ex(9, 2, 1, cw & ext_ctrl[11:8]);
      ex(14, 2, 1, 4'(~(cw & ext_ctrl[11:8])));
      ex(9, 0, 1, 0);
      ex(10, 0, 1, ext_stat[4:0]);
      ex(11, 2, 1, 5'(~ext_stat[14:10]));
    end
    foreach (tt[i]) begin
      ret_time_ns[31:0] = tt[i];
      data_ret_en[7:0] = $random(seed);
      data_out_req[7:0] = $random(seed);
      k = (tt[i] + 24) / 25;
      if (k == 0) k = 1;
      // Return acts two edges after its request at the earliest
      m = (k < 2) ? 2 : k;
      // Per-port ops never share a cycle with all-port ones
      go(0, 0, 0, 8'h01, 0, 0);
      w = data_out_req[7:0] ^ data_invert[7:0];
      go(0, 0, 0, 0, 0, 8'h01);
      ex(12, 0, 1, 1);
      ex(3, 0, m - 1, w);
      ex(3, 0, m,
         (w & ~data_ret_en[7:0]) | (data_invert[7:0] & data_ret_en[7:0]));
      ex(12, 0, m, 0);
      repeat (k + 2) go(0, 0, 0, 0, 0, 0);
    end
    repeat (3) go(0, 0, 0, 0, 0, 0);
    if (q.size() != 0) bad_count++;
    end_of_test();
  end
endmodule // tb_parallel_port_pin_driver
